// File: include/wdt_pg_consts.vh
// constants shared by the supervisory watchdog and power-good logic
`ifndef WDT_PG_CONSTS_VH
`define WDT_PG_CONSTS_VH

// clock and timing figures, times in ns
`define CLK_PERIOD_NS       4
`define DEGLITCH_TIME_NS    180000
`define FIX_DELAY_TIME_NS   248000
`define TICK_LO_TIME_NS     500
`define TICK_HI_TIME_NS     2500
`define TICK_LO_CYCLES      (`TICK_LO_TIME_NS / `CLK_PERIOD_NS)
`define TICK_HI_CYCLES      (`TICK_HI_TIME_NS / `CLK_PERIOD_NS)
`define TIMER_WIDTH         16
`define PRESC_WIDTH         10

// window arithmetic, all in 28-bit tick units
`define CALC_WIDTH          28
`define INIT_WINDOWS        28'h0000008
`define HALF_DIV            28'h0000002
`define NINTH_DIV           28'h0000009
`define OPEN_NINTHS         28'h0000008
`define HOLD_DIV            28'h0000005

// register map (byte addresses)
`define ADDR_WIDTH          12
`define REG_CTRL_OFS        12'h000
`define REG_PERIOD_OFS      12'h004
`define REG_STATUS_OFS      12'h008
`define CTRL_CAP_BIT        0
`define CTRL_RST            1'b0
`define PERIOD_WIDTH        18
`define PERIOD_RST          18'h04E20
`define HTRANS_ACTIVE_BIT   1

// status field positions
`define ST_PG_BIT           0
`define ST_FAULT_BIT        1
`define ST_WD_RUN_BIT       2
`define ST_WD_STATE_LSB     3
`define ST_REG_ON_BIT       6
`define ST_PG_PIN_BIT       7
`define ST_FAULT_PIN_BIT    8
`define ST_PG_STATE_LSB     9

// synchroniser lanes
`define SYNC_WIDTH          12
`define SI_ENABLE           0
`define SI_LOCKOUT          1
`define SI_OVERTEMP         2
`define SI_OUT_GOOD         3
`define SI_DELAY_CMP        4
`define SI_TYPE_SEL         5
`define SI_RANGE_SEL        6
`define SI_RATIO_SEL        7
`define SI_SERVICE          8
`define SI_WATCHDOG_ENABLE_N_N          9
`define SI_PG_PIN           10
`define SI_FAULT_PIN        11

`endif

// File: hdl/pin_sync.v
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module pin_sync #(
	parameter WIDTH = 1
) (
	input  wire             hclk,
	input  wire             hresetn,
	input  wire [WIDTH-1:0] async_in,
	output wire [WIDTH-1:0] sync_out
);
	reg [WIDTH-1:0] s1_ff;
	reg [WIDTH-1:0] s2_ff;
	reg [WIDTH-1:0] s3_ff;
	reg [WIDTH-1:0] stable_ff;
	wire [WIDTH-1:0] nxt_stable;

	// a bit changes only once stages two and three agree
	assign nxt_stable = (s2_ff & s3_ff) | (stable_ff & (s2_ff | s3_ff));
	assign sync_out = stable_ff;

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s1_ff <= {WIDTH{1'b0}};
			s2_ff <= {WIDTH{1'b0}};
			s3_ff <= {WIDTH{1'b0}};
			stable_ff <= {WIDTH{1'b0}};
		end else begin
			s1_ff <= async_in;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
			stable_ff <= nxt_stable;
		end
	end
endmodule

// File: hdl/cycle_timer.v
// restartable cycle counter that flags when its limit is reached
`timescale 1ns/1ps
module cycle_timer #(
	parameter             WIDTH = 16,
	parameter [WIDTH-1:0] LIMIT = {WIDTH{1'b1}}
) (
	input  wire hclk,
	input  wire hresetn,
	input  wire run,
	output wire done
);
	reg  [WIDTH-1:0] count_ff;
	wire [WIDTH-1:0] nxt_count;

	assign done = (count_ff == LIMIT);
	// dropping run restarts the count from zero
	assign nxt_count = !run ? {WIDTH{1'b0}} : (done ? count_ff : count_ff + 1'b1);

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			count_ff <= {WIDTH{1'b0}};
		end else begin
			count_ff <= nxt_count;
		end
	end
endmodule

// File: hdl/window_watchdog_power_good.v
// power-good sequencer and window/standard watchdog with AHB-Lite registers
//
// How it works
// - enable high runs everything, low holds off
// - supply good rises only after full delay
// - supply good drops after deglitch, short dips ignored
// - delay ends when capacitor comparator trips
// - no capacitor selects fixed default delay
// - lockout shuts off, recovery repeats full sequence
// - overtemp off until trip comparator releases
// - type select low window, high standard
// - range select high gives five-times window
// - window is resistor ohms times tick time
// - first open window lasts eight windows
// - ratio low splits window half and half
// - ratio high makes open eight ninths
// - fault on closed service or missed open
// - valid service restarts count, starts closed window in window mode
// - fault pulls output low twenty percent window
// - watchdog runs only enabled and supply good
`timescale 1ns/1ps
`include "wdt_pg_consts.vh"
module window_watchdog_power_good #(
	parameter DEGLITCH_CYCLES  = (`DEGLITCH_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
	parameter FIX_DELAY_CYCLES = (`FIX_DELAY_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
	input  wire        hclk,
	input  wire        hresetn,
	input  wire        hsel,
	input  wire [31:0] haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output wire        hreadyout,
	output wire        hresp,
	output wire [31:0] hrdata,
	input  wire        enable,
	input  wire        low_input_lockout,
	input  wire        overtemp_trip,
	input  wire        output_above_threshold,
	input  wire        delay_threshold_cmp,
	output wire        delay_charge_en,
	output wire        regulator_on,
	input  wire        watchdog_type_select,
	input  wire        period_range_select,
	input  wire        window_ratio_select,
	input  wire        service_input,
	input  wire        watchdog_enable_n,
	input  wire        supply_good_flag_in,
	output wire        supply_good_flag_out,
	output wire        supply_good_flag_oe_n,
	input  wire        fault_output_n_in,
	output wire        fault_output_n_out,
	output wire        fault_output_n_oe_n
);
	localparam PG_OFF    = 3'h0;
	localparam PG_LOW    = 3'h1;
	localparam PG_DELAY  = 3'h2;
	localparam PG_HIGH   = 3'h3;
	localparam PG_GLITCH = 3'h4;

	localparam WD_OFF    = 3'h0;
	localparam WD_INIT   = 3'h1;
	localparam WD_CLOSED = 3'h2;
	localparam WD_OPEN   = 3'h3;
	localparam WD_HOLD   = 3'h4;

	localparam integer            PRESC_LO_N      = `TICK_LO_CYCLES - 1;
	localparam integer            PRESC_HI_N      = `TICK_HI_CYCLES - 1;
	// narrowed on purpose: a count above the timer range would wrap, keep overrides small
	localparam [`TIMER_WIDTH-1:0] DEGLITCH_LIMIT  = DEGLITCH_CYCLES[`TIMER_WIDTH-1:0];
	localparam [`TIMER_WIDTH-1:0] FIX_DELAY_LIMIT = FIX_DELAY_CYCLES[`TIMER_WIDTH-1:0];
	localparam [`PRESC_WIDTH-1:0] PRESC_LO_LAST   = PRESC_LO_N[`PRESC_WIDTH-1:0];
	localparam [`PRESC_WIDTH-1:0] PRESC_HI_LAST   = PRESC_HI_N[`PRESC_WIDTH-1:0];

	// ---- synchronised pins
	wire [`SYNC_WIDTH-1:0] pins_async;
	wire [`SYNC_WIDTH-1:0] pins_s;

	assign pins_async[`SI_ENABLE]    = enable;
	assign pins_async[`SI_LOCKOUT]   = low_input_lockout;
	assign pins_async[`SI_OVERTEMP]  = overtemp_trip;
	assign pins_async[`SI_OUT_GOOD]  = output_above_threshold;
	assign pins_async[`SI_DELAY_CMP] = delay_threshold_cmp;
	assign pins_async[`SI_TYPE_SEL]  = watchdog_type_select;
	assign pins_async[`SI_RANGE_SEL] = period_range_select;
	assign pins_async[`SI_RATIO_SEL] = window_ratio_select;
	assign pins_async[`SI_SERVICE]   = service_input;
	assign pins_async[`SI_WATCHDOG_ENABLE_N_N]   = watchdog_enable_n;
	assign pins_async[`SI_PG_PIN]    = supply_good_flag_in;
	assign pins_async[`SI_FAULT_PIN] = fault_output_n_in;

	pin_sync #(
		.WIDTH    (`SYNC_WIDTH)
	) u_pin_sync (
		.hclk     (hclk),
		.hresetn  (hresetn),
		.async_in (pins_async),
		.sync_out (pins_s)
	);

	// ---- register file over AHB-Lite
	reg                     cap_fitted_ff;
	reg [`PERIOD_WIDTH-1:0] period_ff;
	reg                     wr_pend_ff;
	reg [`ADDR_WIDTH-1:0]   wr_addr_ff;
	reg [31:0]              hrdata_ff;
	reg                     nxt_cap_fitted;
	reg [`PERIOD_WIDTH-1:0] nxt_period;
	reg [31:0]              nxt_rdata;
	wire                    addr_take;
	wire [31:0]             status_word;

	reg [2:0] pg_state_ff;
	reg [2:0] nxt_pg_state;
	reg [2:0] wd_state_ff;
	reg [2:0] nxt_wd_state;
	reg       pg_ff;
	reg       regulator_on_ff;
	reg       delay_charge_ff;
	reg       fault_drive_ff;

	assign addr_take = hsel & htrans[`HTRANS_ACTIVE_BIT] & hready;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = hrdata_ff;

	assign status_word = {
		20'h00000,
		pg_state_ff,
		pins_s[`SI_FAULT_PIN],
		pins_s[`SI_PG_PIN],
		regulator_on_ff,
		wd_state_ff,
		(wd_state_ff != WD_OFF),
		fault_drive_ff,
		pg_ff
	};

	// write lands in the data phase; reads use the updated value to avoid a stale read
	always @* begin
		nxt_cap_fitted = cap_fitted_ff;
		nxt_period = period_ff;
		if (wr_pend_ff && (wr_addr_ff == `REG_CTRL_OFS)) begin
			nxt_cap_fitted = hwdata[`CTRL_CAP_BIT];
		end
		if (wr_pend_ff && (wr_addr_ff == `REG_PERIOD_OFS)) begin
			nxt_period = hwdata[`PERIOD_WIDTH-1:0];
		end
	end

	always @* begin
		case (haddr[`ADDR_WIDTH-1:0])
			`REG_CTRL_OFS: begin
				nxt_rdata = 32'h00000000;
				nxt_rdata[`CTRL_CAP_BIT] = nxt_cap_fitted;
			end
			`REG_PERIOD_OFS: begin
				nxt_rdata = {{(32-`PERIOD_WIDTH){1'b0}}, nxt_period};
			end
			`REG_STATUS_OFS: begin
				nxt_rdata = status_word;
			end
			default: begin
				nxt_rdata = 32'h00000000;
			end
		endcase
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cap_fitted_ff <= `CTRL_RST;
			period_ff <= `PERIOD_RST;
			wr_pend_ff <= 1'b0;
			wr_addr_ff <= {`ADDR_WIDTH{1'b0}};
			hrdata_ff <= 32'h00000000;
		end else begin
			cap_fitted_ff <= nxt_cap_fitted;
			period_ff <= nxt_period;
			wr_pend_ff <= addr_take & hwrite;
			if (addr_take) begin
				wr_addr_ff <= haddr[`ADDR_WIDTH-1:0];
			end
			if (addr_take && !hwrite) begin
				hrdata_ff <= nxt_rdata;
			end
		end
	end

	// ---- power-good sequencer
	wire run_ok;
	wire out_good;
	wire fix_done;
	wire glitch_done;
	wire delay_over;

	assign run_ok = pins_s[`SI_ENABLE] & ~pins_s[`SI_LOCKOUT] & ~pins_s[`SI_OVERTEMP];
	assign out_good = pins_s[`SI_OUT_GOOD];

	cycle_timer #(
		.WIDTH   (`TIMER_WIDTH),
		.LIMIT   (FIX_DELAY_LIMIT)
	) u_fix_delay (
		.hclk    (hclk),
		.hresetn (hresetn),
		.run     (pg_state_ff == PG_DELAY),
		.done    (fix_done)
	);

	cycle_timer #(
		.WIDTH   (`TIMER_WIDTH),
		.LIMIT   (DEGLITCH_LIMIT)
	) u_deglitch (
		.hclk    (hclk),
		.hresetn (hresetn),
		.run     (pg_state_ff == PG_GLITCH),
		.done    (glitch_done)
	);

	assign delay_over = cap_fitted_ff ? pins_s[`SI_DELAY_CMP] : fix_done;

	always @* begin
		nxt_pg_state = pg_state_ff;
		case (pg_state_ff)
			PG_OFF: begin
				nxt_pg_state = PG_LOW;
			end
			PG_LOW: begin
				if (out_good) begin
					nxt_pg_state = PG_DELAY;
				end
			end
			PG_DELAY: begin
				if (!out_good) begin
					nxt_pg_state = PG_LOW;
				end else if (delay_over) begin
					nxt_pg_state = PG_HIGH;
				end
			end
			PG_HIGH: begin
				if (!out_good) begin
					nxt_pg_state = PG_GLITCH;
				end
			end
			PG_GLITCH: begin
				if (out_good) begin
					nxt_pg_state = PG_HIGH;
				end else if (glitch_done) begin
					nxt_pg_state = PG_LOW;
				end
			end
			default: begin
				nxt_pg_state = PG_OFF;
			end
		endcase
		if (!run_ok) begin
			nxt_pg_state = PG_OFF;
		end
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pg_state_ff <= PG_OFF;
			pg_ff <= 1'b0;
			regulator_on_ff <= 1'b0;
			delay_charge_ff <= 1'b0;
		end else begin
			pg_state_ff <= nxt_pg_state;
			pg_ff <= (nxt_pg_state == PG_HIGH) | (nxt_pg_state == PG_GLITCH);
			regulator_on_ff <= run_ok;
			delay_charge_ff <= (nxt_pg_state == PG_DELAY);
		end
	end

	// capacitor is discharged whenever the delay is not running
	assign delay_charge_en = delay_charge_ff;
	assign regulator_on = regulator_on_ff;
	assign supply_good_flag_out = 1'b0;
	assign supply_good_flag_oe_n = pg_ff;

	// ---- watchdog
	reg  [`PRESC_WIDTH-1:0] presc_ff;
	reg  [23:0]             wcnt_ff;
	reg                     svc_prev_ff;
	reg                     clr_cnt;
	wire                    wd_run;
	wire                    window_mode;
	wire                    ratio_high;
	wire [`PRESC_WIDTH-1:0] presc_last;
	wire                    tick;
	wire                    svc_rise;
	wire [`CALC_WIDTH-1:0]  r_val;
	wire [`CALC_WIDTH-1:0]  c_val;
	wire                    end_init;
	wire                    end_closed;
	wire                    end_open;
	wire                    end_hold;

	assign wd_run = ~pins_s[`SI_WATCHDOG_ENABLE_N_N] & pg_ff & run_ok;
	// type select low is window mode
	assign window_mode = ~pins_s[`SI_TYPE_SEL];
	assign ratio_high = pins_s[`SI_RATIO_SEL];

	assign presc_last = pins_s[`SI_RANGE_SEL] ? PRESC_HI_LAST : PRESC_LO_LAST;
	assign tick = (presc_ff == presc_last);

	assign svc_rise = pins_s[`SI_SERVICE] & ~svc_prev_ff;

	assign r_val = {{(`CALC_WIDTH-`PERIOD_WIDTH){1'b0}}, period_ff};
	assign c_val = {{(`CALC_WIDTH-24){1'b0}}, wcnt_ff};

	assign end_init = (c_val >= r_val * `INIT_WINDOWS);
	assign end_closed = ratio_high ? (c_val * `NINTH_DIV >= r_val)
		: (c_val * `HALF_DIV >= r_val);
	assign end_open = !window_mode ? (c_val >= r_val)
		: (ratio_high ? (c_val * `NINTH_DIV >= r_val * `OPEN_NINTHS)
		: (c_val * `HALF_DIV >= r_val));
	assign end_hold = (c_val * `HOLD_DIV >= r_val);

	always @* begin
		nxt_wd_state = wd_state_ff;
		clr_cnt = 1'b0;
		case (wd_state_ff)
			WD_OFF: begin
				nxt_wd_state = WD_INIT;
			end
			WD_INIT: begin
				if (svc_rise) begin
					nxt_wd_state = window_mode ? WD_CLOSED : WD_OPEN;
				end else if (end_init) begin
					nxt_wd_state = WD_HOLD;
				end
			end
			WD_CLOSED: begin
				if (svc_rise) begin
					nxt_wd_state = WD_HOLD;
				end else if (end_closed) begin
					nxt_wd_state = WD_OPEN;
				end
			end
			WD_OPEN: begin
				if (svc_rise) begin
					nxt_wd_state = window_mode ? WD_CLOSED : WD_OPEN;
					clr_cnt = 1'b1;
				end else if (end_open) begin
					nxt_wd_state = WD_HOLD;
				end
			end
			WD_HOLD: begin
				if (end_hold) begin
					nxt_wd_state = WD_INIT;
				end
			end
			default: begin
				nxt_wd_state = WD_OFF;
			end
		endcase
		if (!wd_run) begin
			nxt_wd_state = WD_OFF;
		end
		if (nxt_wd_state != wd_state_ff) begin
			clr_cnt = 1'b1;
		end
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wd_state_ff <= WD_OFF;
			presc_ff <= {`PRESC_WIDTH{1'b0}};
			wcnt_ff <= 24'h000000;
			svc_prev_ff <= 1'b0;
			fault_drive_ff <= 1'b0;
		end else begin
			wd_state_ff <= nxt_wd_state;
			svc_prev_ff <= pins_s[`SI_SERVICE];
			// window timing restarts cleanly at every state change
			if (clr_cnt || tick) begin
				presc_ff <= {`PRESC_WIDTH{1'b0}};
			end else begin
				presc_ff <= presc_ff + 1'b1;
			end
			if (clr_cnt) begin
				wcnt_ff <= 24'h000000;
			end else if (tick) begin
				wcnt_ff <= wcnt_ff + 1'b1;
			end
			fault_drive_ff <= (nxt_wd_state == WD_HOLD);
		end
	end

	assign fault_output_n_out = 1'b0;
	assign fault_output_n_oe_n = ~fault_drive_ff;
endmodule

// File: testbench/wdpg_chk.sv
// port-level assertions for the supervisory block
`timescale 1ns/1ps
module wdpg_chk #(
	parameter DEGLITCH_CYCLES  = 45000,
	parameter FIX_DELAY_CYCLES = 62000
) (
	input logic hclk,
	input logic hresetn,
	input logic enable,
	input logic low_input_lockout,
	input logic overtemp_trip,
	input logic output_above_threshold,
	input logic delay_threshold_cmp,
	input logic delay_charge_en,
	input logic regulator_on,
	input logic watchdog_enable_n,
	input logic supply_good_flag_oe_n,
	input logic fault_output_n_oe_n
);
	int   chg_cnt;
	int   lo_cnt;
	logic chg_q;
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// keep the length of the last charge run so the flag edge can be judged after it ends
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			chg_cnt <= 0;
			lo_cnt  <= 0;
			chg_q   <= 1'b0;
		end else begin
			chg_q  <= delay_charge_en;
			lo_cnt <= output_above_threshold ? 0 : lo_cnt + 1;
			if (delay_charge_en)
				chg_cnt <= chg_q ? chg_cnt + 1 : 1;
		end
	end
	reg_on_a: assert property (
		(enable && !low_input_lockout && !overtemp_trip) [*8] |-> regulator_on)
		else $error("regulator stays off");
	en_off_a: assert property (
		!enable [*8] |-> !regulator_on && !supply_good_flag_oe_n)
		else $error("output on while disabled");
	lockout_off_a: assert property (
		low_input_lockout [*8] |-> !regulator_on && !delay_charge_en)
		else $error("output on in lockout");
	overtemp_off_a: assert property (
		overtemp_trip [*8] |-> !regulator_on && !supply_good_flag_oe_n)
		else $error("output on when hot");
	pg_delay_a: assert property (
		$rose(supply_good_flag_oe_n) |->
		chg_cnt >= FIX_DELAY_CYCLES - 1 || $past(delay_threshold_cmp, 3))
		else $error("flag good before delay");
	deglitch_a: assert property (
		$fell(supply_good_flag_oe_n) && regulator_on && enable && !low_input_lockout
		&& !overtemp_trip |-> lo_cnt >= DEGLITCH_CYCLES)
		else $error("flag dropped before deglitch");
	out_low_a: assert property (
		!output_above_threshold [*8] |-> !delay_charge_en)
		else $error("delay runs with output low");
	wd_gate_a: assert property (
		(watchdog_enable_n || !supply_good_flag_oe_n) [*8] |-> fault_output_n_oe_n)
		else $error("fault driven while watchdog off");
	pg_up_c: cover property ($rose(supply_good_flag_oe_n));
	fault_c: cover property ($fell(fault_output_n_oe_n));
	dip_c: cover property ($fell(supply_good_flag_oe_n) && regulator_on);
endmodule

// File: testbench/mcu_model.sv
// controller side: sends service pulses of a fixed width on request
`timescale 1ns/1ps
module mcu_model #(
	parameter HOLD_CYCLES = 25000
) (
	input  logic hclk,
	input  logic kick,
	output logic service_input
);
	int cnt_ff = 0;
	initial service_input = 1'b0;
	always @(posedge hclk) begin
		if (kick && cnt_ff == 0) begin
			service_input <= 1'b1;
			cnt_ff        <= HOLD_CYCLES;
		end else if (cnt_ff > 1) begin
			cnt_ff <= cnt_ff - 1;
		end else begin
			service_input <= 1'b0;
			cnt_ff        <= 0;
		end
	end
endmodule

// File: testbench/window_watchdog_power_good_tb.sv
// self-checking bench for the supervisory watchdog and power-good block
`timescale 1ns/1ps
module window_watchdog_power_good_tb;
	localparam int DG = 20;
	localparam int FX = 30;
	logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
	logic [1:0]  htrans = 2'h0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rv;
	logic        hreadyout, hresp, dchg, reg_on, pg_oe_n, pg_o, ft_oe_n, ft_o, svc;
	logic        en = 1'b1, lock = 1'b0, ot = 1'b0, out_ok = 1'b0, dcmp = 1'b0;
	logic        ty = 1'b0, rg = 1'b0, ra = 1'b0, wd_n = 1'b1, kick = 1'b0;
	int          err_total = 0, total_checks = 0, n, w, cyc_n = 0;

	// open-drain pins are pulled up when released
	window_watchdog_power_good #(.DEGLITCH_CYCLES(DG), .FIX_DELAY_CYCLES(FX)) uut (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .enable(en),
		.low_input_lockout(lock), .overtemp_trip(ot), .output_above_threshold(out_ok),
		.delay_threshold_cmp(dcmp), .delay_charge_en(dchg), .regulator_on(reg_on),
		.watchdog_type_select(ty), .period_range_select(rg), .window_ratio_select(ra),
		.service_input(svc), .watchdog_enable_n(wd_n),
		.supply_good_flag_in(pg_oe_n | pg_o), .supply_good_flag_out(pg_o),
		.supply_good_flag_oe_n(pg_oe_n), .fault_output_n_in(ft_oe_n | ft_o),
		.fault_output_n_out(ft_o), .fault_output_n_oe_n(ft_oe_n));
	mcu_model #(.HOLD_CYCLES(20)) mcu (.hclk(hclk), .kick(kick), .service_input(svc));

	always #2 hclk = ~hclk;
	// about three times the planned run
	always @(posedge hclk) begin
		cyc_n++;
		if (cyc_n == 100000) begin
			err_total++;
			stop_test;
		end
	end

	task automatic stop_test;
		$display("checks %0d errors %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, exp);
		total_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge hclk);
	endtask
	task automatic ahb(input logic wr, input logic [31:0] a, d);
		@(posedge hclk);
		hsel   <= 1'b1;
		htrans <= 2'h2;
		hwrite <= wr;
		haddr  <= a;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rv = hrdata;
	endtask
	// sampled on the falling edge so edge updates have landed
	task automatic wt(input logic sel, v, input int lim);
		n = 0;
		while (n < lim && (sel ? ft_oe_n : pg_oe_n) !== v) begin
			@(negedge hclk);
			n++;
		end
	endtask
	task automatic sv(input int d);
		cyc(d);
		kick <= 1'b1;
		@(posedge hclk);
		kick <= 1'b0;
	endtask
	function automatic int win(input int p, input logic r);
		return p * (r ? 625 : 125);
	endfunction
	function automatic logic near(input int v, e, tol);
		return v > e - tol && v < e + tol;
	endfunction
	// settings change only with the watchdog off, so each run starts from init
	task automatic wds(input logic t, r, q, input int p);
		@(posedge hclk);
		wd_n <= 1'b1;
		ahb(1'b1, 32'h4, p);
		ty <= t;
		rg <= r;
		ra <= q;
		cyc(10);
		wd_n <= 1'b0;
		w = win(p, r);
	endtask

	initial begin
		void'($urandom(45));
		cyc(4);
		hresetn <= 1'b1;
		ahb(1'b0, 32'h0, 32'h0);
		chk(rv, 32'h0);
		ahb(1'b0, 32'h4, 32'h0);
		chk(rv, 32'h4E20);
		ahb(1'b1, 32'hC, 32'hFFFFFFFF);
		ahb(1'b0, 32'hC, 32'h0);
		chk(rv, 32'h0);
		ahb(1'b0, 32'h8, 32'h0);
		chk(rv[6], 1'b1);
		chk(hresp, 1'b0);
		out_ok <= 1'b1;
		wt(1'b0, 1'b1, 200);
		chk(n >= FX && n <= FX + 12, 1'b1);
		// pin readback passes the synchroniser, so let it settle first
		cyc(8);
		ahb(1'b0, 32'h8, 32'h0);
		chk(rv, 32'h000007C1);
		@(posedge hclk);
		out_ok <= 1'b0;
		cyc(DG / 2);
		out_ok <= 1'b1;
		wt(1'b0, 1'b0, DG + 20);
		chk(n, DG + 20);
		@(posedge hclk);
		out_ok <= 1'b0;
		wt(1'b0, 1'b0, 200);
		chk(n >= DG && n <= DG + 12, 1'b1);
		ahb(1'b1, 32'h0, 32'h1);
		out_ok <= 1'b1;
		wt(1'b0, 1'b1, 3 * FX);
		chk(n, 3 * FX);
		@(posedge hclk);
		dcmp <= 1'b1;
		wt(1'b0, 1'b1, 20);
		chk(n <= 12, 1'b1);
		@(posedge hclk);
		dcmp <= 1'b0;
		ahb(1'b1, 32'h0, 32'h0);
		for (int k = 0; k < 2; k++) begin
			lock   <= (k == 0);
			ot     <= (k == 1);
			out_ok <= 1'b0;
			wt(1'b0, 1'b0, 20);
			chk(n <= 12, 1'b1);
			cyc(50);
			lock   <= 1'b0;
			ot     <= 1'b0;
			out_ok <= 1'b1;
			wt(1'b0, 1'b1, 200);
			chk(n >= FX && n <= FX + 20, 1'b1);
			@(posedge hclk);
		end
		wds(1'b0, 1'b0, 1'b0, 10);
		sv(200 + $urandom % 3000);
		sv(100 + $urandom % 300);
		wt(1'b1, 1'b0, 60);
		chk(n < 60, 1'b1);
		cyc(8);
		ahb(1'b0, 32'h8, 32'h0);
		chk(rv, 32'h000006E7);
		wt(1'b1, 1'b1, 600);
		chk(near(n, w / 5, 135), 1'b1);
		sv(300);
		sv(w / 2 + 100 + $urandom % 300);
		wt(1'b1, 1'b0, 3 * w);
		chk(near(n, w, 150), 1'b1);
		wt(1'b1, 1'b1, w);
		wds(1'b0, 1'b0, 1'b1, 9);
		sv(300);
		sv(300);
		wt(1'b1, 1'b0, 3 * w);
		chk(near(n, w, 150), 1'b1);
		wt(1'b1, 1'b1, w);
		wds(1'b1, 1'b0, 1'b0, 10);
		sv(300);
		sv(150);
		wt(1'b1, 1'b0, 3 * w);
		chk(near(n, w, 150), 1'b1);
		wt(1'b1, 1'b1, w);
		wds(1'b0, 1'b1, 1'b0, 5);
		wt(1'b1, 1'b0, 9 * w);
		chk(near(n, 8 * w, 700), 1'b1);
		@(posedge hclk);
		wd_n <= 1'b1;
		wt(1'b1, 1'b1, 20);
		chk(n <= 12, 1'b1);
		@(posedge hclk);
		en <= 1'b0;
		wt(1'b0, 1'b0, 20);
		chk(n <= 12, 1'b1);
		cyc(12);
		stop_test;
	end
endmodule

bind window_watchdog_power_good wdpg_chk #(.DEGLITCH_CYCLES(DEGLITCH_CYCLES),
	.FIX_DELAY_CYCLES(FIX_DELAY_CYCLES)) chk (.hclk(hclk), .hresetn(hresetn),
	.enable(enable), .low_input_lockout(low_input_lockout), .overtemp_trip(overtemp_trip),
	.output_above_threshold(output_above_threshold),
	.delay_threshold_cmp(delay_threshold_cmp), .delay_charge_en(delay_charge_en),
	.regulator_on(regulator_on), .watchdog_enable_n(watchdog_enable_n),
	.supply_good_flag_oe_n(supply_good_flag_oe_n), .fault_output_n_oe_n(fault_output_n_oe_n));
